/* shared/sram_host_pkg.sv */
package sram_host_pkg;
    // Device map
    localparam logic [16:0] CLOCK_CONTROL_ADDR = 17'h1fff8;
    localparam logic [16:0] TIME_FIRST_ADDR = 17'h1fff9;
    localparam int READ_HALT_BIT = 6;
    localparam int SET_CLOCK_BIT = 7;
    localparam int ADDR_W = 17;

    // Own AXI register offsets
    localparam logic [3:0] REG_CMD = 4'h0;
    localparam logic [3:0] REG_ADDR = 4'h4;
    localparam logic [3:0] REG_WDATA = 4'h8;
    localparam logic [3:0] REG_STATUS = 4'hc;
    localparam int CMD_GO_BIT = 0;
    localparam int CMD_WRITE_BIT = 1;
    localparam int CMD_HALT_BIT = 2;
    localparam int CMD_RELEASE_BIT = 3;

    // Access timing, ns, at the 20 MHz clock
    localparam int CLK_NS = 50;
    localparam int ADDR_ACCESS_NS = 85;
    localparam int WRITE_PULSE_NS = 60;
    localparam int RECOVERY_NS = 15;
    localparam int HIZ_NS = 30;
    localparam logic [3:0] READ_CYC = 4'((ADDR_ACCESS_NS + CLK_NS - 1) / CLK_NS + 1);
    localparam logic [3:0] WRITE_CYC = 4'((WRITE_PULSE_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [3:0] REC_CYC = 4'((RECOVERY_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [3:0] HIZ_CYC = 4'((HIZ_NS + CLK_NS - 1) / CLK_NS);

    typedef enum logic [2:0] {
        PH_IDLE = 3'b000,
        PH_SETUP = 3'b001,
        PH_STROBE = 3'b011,
        PH_RECOVER = 3'b010,
        PH_PWRWAIT = 3'b110
    } phase_t;

    typedef struct packed {
        logic [16:0] byte_addr;
        logic chip_sel_n;
        logic out_en_n;
        logic write_n;
        logic [7:0] dout;
        logic dout_oe_n;
    } pins_t;
endpackage

/* verilog/sram_cycle.sv */
`timescale 1ns/1ps
`default_nettype none
module sram_cycle (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Request
    input wire logic start,
    input wire logic is_write,
    input wire logic [16:0] addr,
    input wire logic [7:0] wdata,
    input wire logic supply_ok,
    output logic busy,
    output logic done,
    output logic [7:0] rdata,
    // Device pins
    output sram_host_pkg::pins_t pins,
    input wire logic [7:0] byte_lines_in
);
    typedef struct packed {
        sram_host_pkg::phase_t ph;
        logic [3:0] cnt;
        logic wr;
        logic done;
        logic [7:0] rdata;
        sram_host_pkg::pins_t p;
    } cyc_state_t;
    cyc_state_t s;
    cyc_state_t next_s;

    always_comb begin
        next_s = s;
        next_s.done = 1'b0;
        unique case (s.ph)
            sram_host_pkg::PH_IDLE: begin
                if (start && supply_ok) begin
                    // Address set a full cycle before any strobe falls
                    next_s.p.byte_addr = addr;
                    next_s.wr = is_write;
                    next_s.p.dout = wdata;
                    next_s.ph = sram_host_pkg::PH_SETUP;
                end
            end
            sram_host_pkg::PH_SETUP: begin
                next_s.p.chip_sel_n = 1'b0;
                // [RL9] output enable held high on writes
                next_s.p.out_en_n = s.wr;
                next_s.p.write_n = ~s.wr;
                next_s.p.dout_oe_n = ~s.wr;
                next_s.cnt = s.wr ? sram_host_pkg::WRITE_CYC : sram_host_pkg::READ_CYC;
                next_s.ph = sram_host_pkg::PH_STROBE;
            end
            sram_host_pkg::PH_STROBE: begin
                if (s.cnt > 4'h1) begin
                    next_s.cnt = s.cnt - 4'h1;
                end else begin
                    // [RL7] strobes rise together, address held
                    next_s.p.chip_sel_n = 1'b1;
                    next_s.p.out_en_n = 1'b1;
                    next_s.p.write_n = 1'b1;
                    // [RL3] sample after the last access interval
                    if (!s.wr) begin
                        next_s.rdata = byte_lines_in;
                    end
                    next_s.cnt = s.wr ? sram_host_pkg::REC_CYC : sram_host_pkg::HIZ_CYC;
                    next_s.ph = sram_host_pkg::PH_RECOVER;
                end
            end
            sram_host_pkg::PH_RECOVER: begin
                // [RL8] data held past the terminating edge
                if (s.cnt > 4'h1) begin
                    next_s.cnt = s.cnt - 4'h1;
                end else begin
                    next_s.p.dout_oe_n = 1'b1;
                    next_s.done = 1'b1;
                    next_s.ph = sram_host_pkg::PH_IDLE;
                end
            end
            default: begin
                next_s.ph = sram_host_pkg::PH_IDLE;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '{ph: sram_host_pkg::PH_IDLE, cnt: 4'h0, wr: 1'b0, done: 1'b0, rdata: 8'h00,
                   p: '{byte_addr: 17'h00000, chip_sel_n: 1'b1, out_en_n: 1'b1, write_n: 1'b1,
                        dout: 8'h00, dout_oe_n: 1'b1}};
        end else begin
            s <= next_s;
        end
    end

    assign busy = (s.ph != sram_host_pkg::PH_IDLE);
    assign done = s.done;
    assign rdata = s.rdata;
    assign pins = s.p;

    a_write_no_oe: assert property (@(posedge aclk) disable iff (!aresetn)
        !s.p.write_n |-> s.p.out_en_n) else $error("output enable low during write"); // [RL9]
    a_read_width: assert property (@(posedge aclk) disable iff (!aresetn)
        $fell(s.p.out_en_n) |-> !s.p.out_en_n [*3]) else $error("read strobe too short"); // [RL3]
    a_addr_stable: assert property (@(posedge aclk) disable iff (!aresetn)
        !s.p.chip_sel_n |=> $stable(s.p.byte_addr)) else $error("address moved in cycle"); // [RL7]
    a_data_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(s.p.write_n) |-> !s.p.dout_oe_n) else $error("write data dropped early"); // [RL8]
    c_write: cover property (@(posedge aclk) $rose(s.p.write_n));
    c_read: cover property (@(posedge aclk) $rose(s.p.out_en_n));
    c_done: cover property (@(posedge aclk) s.done);
endmodule
`default_nettype wire

/* verilog/sram_rtc_host.sv */
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// [RL1] Device reads with write high, select low
// [RL2] Seventeen address bits pick one byte
// [RL3] Data valid after slowest access interval
// [RL4] Early enabled outputs show garbage first
// [RL5] Address change makes outputs indeterminate
// [RL6] Write spans both strobes low
// [RL7] Host holds address, honours recovery
// [RL8] Write data held around terminating edge
// [RL9] Host keeps output enable high writing
// [RL10] Falling write strobe turns outputs off
// [RL11] Simultaneous strobes keep outputs floating
// [RL12] Supply loss deselects and protects
// [RL13] Power fail spoils only written byte
// [RL14] Protection lingers through recovery after powerup
// [RL15] Eight registers sit atop memory
// [RL16] Visible copies refresh together
// [RL17] Time registers are BCD
// [RL18] Host halts updates before reading time
// [RL19] Read-halt bit freezes visible time
// [RL20] Halt keeps time, counters run
// [RL21] Refresh resumes one second after clear
// [RL22] Visible time refreshes every second
// [RL23] Power-up clears halt bits
// [RL24] Supply-good input models voltage sensing
// [RL25] Register bytes use ordinary strobes
module sram_rtc_host (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite slave
    input wire logic [3:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    input wire logic [3:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    // Supply status
    input wire logic supply_good,
    // Device pins
    output logic [16:0] byte_addr,
    output logic chip_sel_n,
    output logic out_en_n,
    output logic write_n,
    output logic [7:0] byte_lines_out,
    output logic byte_lines_oe_n,
    input wire logic [7:0] byte_lines_in
);
    typedef struct packed {
        logic [16:0] addr;
        logic [7:0] wdata;
        logic go;
        logic wr;
        logic [1:0] seq;
        logic err;
        logic bvalid;
        logic rvalid;
        logic [31:0] rdata;
    } host_state_t;
    host_state_t s;
    host_state_t next_s;

    logic busy;
    logic done;
    logic [7:0] rdata;
    logic start;
    logic start_wr;
    logic [16:0] start_addr;
    logic [7:0] start_wdata;
    logic wr_fire;
    logic rd_fire;
    sram_host_pkg::pins_t pins;

    // Halt sequence: seq 1 sets read-halt, seq 2 clears it
    always_comb begin
        start = 1'b0;
        start_wr = s.wr;
        start_addr = s.addr;
        start_wdata = s.wdata;
        if (s.seq != 2'b00) begin
            start = 1'b1;
            start_wr = 1'b1;
            // [RL19] read-halt bit in the control byte
            start_addr = sram_host_pkg::CLOCK_CONTROL_ADDR;
            start_wdata = 8'h00;
            start_wdata[sram_host_pkg::READ_HALT_BIT] = (s.seq == 2'b01);
        end else if (s.go) begin
            start = 1'b1;
        end
    end

    assign wr_fire = s_awvalid && s_wvalid && !s.bvalid;
    assign rd_fire = s_arvalid && !s.rvalid;
    assign s_awready = wr_fire;
    assign s_wready = wr_fire;
    assign s_arready = rd_fire;

    always_comb begin
        next_s = s;
        if (start && !busy) begin
            next_s.go = 1'b0;
            next_s.seq = 2'b00;
        end
        // [RL12] refused while supply bad
        if (start && !supply_good) begin
            next_s.err = 1'b1;
            next_s.go = 1'b0;
            next_s.seq = 2'b00;
        end
        if (wr_fire) begin
            next_s.bvalid = 1'b1;
            unique case (s_awaddr)
                sram_host_pkg::REG_ADDR: begin
                    next_s.addr = s_wdata[16:0];
                end
                sram_host_pkg::REG_WDATA: begin
                    if (s_wstrb[0]) begin
                        next_s.wdata = s_wdata[7:0];
                    end
                end
                sram_host_pkg::REG_CMD: begin
                    if (s_wstrb[0] && !busy && !s.go && s.seq == 2'b00) begin
                        // [RL18] halt before reading time
                        if (s_wdata[sram_host_pkg::CMD_HALT_BIT]) begin
                            next_s.seq = 2'b01;
                        end else if (s_wdata[sram_host_pkg::CMD_RELEASE_BIT]) begin
                            next_s.seq = 2'b10;
                        end else if (s_wdata[sram_host_pkg::CMD_GO_BIT]) begin
                            next_s.go = 1'b1;
                            next_s.wr = s_wdata[sram_host_pkg::CMD_WRITE_BIT];
                        end
                        next_s.err = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end
        if (s.bvalid && s_bready) begin
            next_s.bvalid = 1'b0;
        end
        if (rd_fire) begin
            next_s.rvalid = 1'b1;
            unique case (s_araddr)
                sram_host_pkg::REG_ADDR: next_s.rdata = {15'h0000, s.addr};
                sram_host_pkg::REG_WDATA: next_s.rdata = {24'h000000, s.wdata};
                sram_host_pkg::REG_STATUS: next_s.rdata = {20'h00000, supply_good, s.err,
                                                           busy | s.go | (s.seq != 2'b00), 1'b0, rdata};
                default: next_s.rdata = 32'h00000000;
            endcase
        end else if (s.rvalid && s_rready) begin
            next_s.rvalid = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '{addr: 17'h00000, wdata: 8'h00, go: 1'b0, wr: 1'b0, seq: 2'b00,
                   err: 1'b0, bvalid: 1'b0, rvalid: 1'b0, rdata: 32'h00000000};
        end else begin
            s <= next_s;
        end
    end

    // [RL25] register bytes use the same cycle engine
    sram_cycle cyc (
        .aclk(aclk),
        .aresetn(aresetn),
        .start(start && supply_good),
        .is_write(start_wr),
        .addr(start_addr),
        .wdata(start_wdata),
        .supply_ok(supply_good),
        .busy(busy),
        .done(done),
        .rdata(rdata),
        .pins(pins),
        .byte_lines_in(byte_lines_in)
    );

    assign byte_addr = pins.byte_addr;
    assign chip_sel_n = pins.chip_sel_n;
    assign out_en_n = pins.out_en_n;
    assign write_n = pins.write_n;
    assign byte_lines_out = pins.dout;
    assign byte_lines_oe_n = pins.dout_oe_n;
    assign s_bresp = 2'b00;
    assign s_bvalid = s.bvalid;
    assign s_rresp = 2'b00;
    assign s_rvalid = s.rvalid;
    assign s_rdata = s.rdata;

    a_bus_idle_out: assert property (@(posedge aclk) disable iff (!aresetn)
        byte_lines_oe_n == 1'b0 |-> out_en_n) else $error("both sides drive lines"); // [RL9]
    a_rvalid_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata)) else $error("read answer dropped");
    a_bvalid_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        s_bvalid && !s_bready |=> s_bvalid) else $error("write answer dropped");
    a_nogo_bad_supply: assert property (@(posedge aclk) disable iff (!aresetn)
        !supply_good && !busy |=> chip_sel_n) else $error("access with supply bad"); // [RL12]
    c_halt: cover property (@(posedge aclk) s.seq == 2'b01 ##[1:20] done);
    c_rd: cover property (@(posedge aclk) rd_fire);
endmodule
`default_nettype wire

/* sim/sram_dev_model.sv */
`timescale 1ns/1ps
`default_nettype none
module sram_dev_model #(
    parameter int TICK_NS = 20000,
    parameter int ACC_NS = 85,
    parameter int REC_NS = 500
) (
    // Host pins
    input wire logic [16:0] byte_addr,
    input wire logic chip_sel_n,
    input wire logic out_en_n,
    input wire logic write_n,
    input wire logic [7:0] host_d,
    input wire logic host_oe_n,
    input wire logic supply_good,
    // Resolved data lines
    output logic [7:0] byte_lines
);
    localparam logic [16:0] CTRL = 17'h1fff8;
    localparam logic [16:0] SECS = 17'h1fff9;
    logic [7:0] mem [0:131071];
    logic [7:0] last = 8'h00;
    logic [7:0] sec_cnt = 8'h00;
    logic ok = 1'b0;
    logic halt = 1'b0;
    logic drive;
    logic drive_late;
    logic [16:0] addr_late;
    logic [7:0] rd_val;
    assign drive = ok && !chip_sel_n && !out_en_n && write_n;
    // unknown until access settles, so an early sample fails
    assign #(ACC_NS) addr_late = byte_addr;
    assign #(ACC_NS) drive_late = drive;
    assign rd_val = (drive_late && addr_late == byte_addr) ? mem[byte_addr] : 8'hxx;
    // No pull-up, so a released line shows the inverse of its last level
    assign byte_lines = drive ? rd_val : (!host_oe_n ? host_d : ~last);
    always @(byte_lines) if (drive || !host_oe_n) last = byte_lines;
    initial begin
        mem[CTRL] = 8'h00;
        mem[SECS] = 8'h00;
    end
    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        if (v == 8'h59) return 8'h00;
        if (v[3:0] == 4'h9) return {v[7:4] + 4'h1, 4'h0};
        return v + 8'h01;
    endfunction
    initial forever begin
        wait (supply_good === 1'b1);
        #REC_NS;
        ok = supply_good;
        halt = 1'b0;
        mem[CTRL][7:6] = 2'b00;
        wait (supply_good !== 1'b1);
        ok = 1'b0;
    end
    always @(posedge (chip_sel_n | write_n)) begin
        if (ok) begin
            mem[byte_addr] = byte_lines;
            if (byte_addr == CTRL) halt = byte_lines[6];
        end
    end
    initial forever begin
        #TICK_NS;
        sec_cnt = bcd_inc(sec_cnt);
    end
    initial forever begin
        wait (!halt);
        #TICK_NS;
        if (!halt) mem[SECS] = sec_cnt;
    end
endmodule
`default_nettype wire

/* sim/tb_sram_rtc_host.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_sram_rtc_host;
    localparam int TICK = 400;
    localparam logic [3:0] RD = 4'h1 << sram_host_pkg::CMD_GO_BIT;
    localparam logic [3:0] WR = RD | (4'h1 << sram_host_pkg::CMD_WRITE_BIT);
    localparam logic [3:0] HALT = 4'h1 << sram_host_pkg::CMD_HALT_BIT;
    localparam logic [3:0] REL = 4'h1 << sram_host_pkg::CMD_RELEASE_BIT;
    localparam logic [16:0] CA = sram_host_pkg::CLOCK_CONTROL_ADDR;
    localparam logic [16:0] SA = sram_host_pkg::TIME_FIRST_ADDR;
    typedef struct packed {
        logic [16:0] a;
        logic [7:0] d;
    } row_t;
    row_t rows [6] = '{'{17'h00000, 8'ha5}, '{17'h1ffef, 8'h5a}, '{17'h10000, 8'hff},
        '{17'h00001, 8'h00}, '{17'h0aaaa, 8'h3c}, '{17'h1fff2, 8'h45}};
    logic aclk = 1'b0, aresetn = 1'b0, supply_good = 1'b1;
    logic [3:0] s_awaddr = 4'h0, s_araddr = 4'h0, s_wstrb = 4'hf;
    logic [31:0] s_wdata = 32'h0, s_rdata;
    logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0, s_rready = 1'b0;
    logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
    logic [1:0] s_bresp, s_rresp;
    logic [16:0] byte_addr, last_addr = 17'h0;
    logic chip_sel_n, out_en_n, write_n, byte_lines_oe_n, last_sel_n = 1'b1;
    logic [7:0] byte_lines_out, byte_lines_in, s0;
    logic [31:0] st;
    int num_errors = 0, cmp_count = 0;
    sram_rtc_host u_sram_rtc_host (.aclk, .aresetn, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb,
        .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata,
        .s_rresp, .s_rvalid, .s_rready, .supply_good, .byte_addr, .chip_sel_n, .out_en_n, .write_n,
        .byte_lines_out, .byte_lines_oe_n, .byte_lines_in);
    sram_dev_model #(.TICK_NS(TICK * 50), .ACC_NS(sram_host_pkg::ADDR_ACCESS_NS), .REC_NS(500))
        u_sram_dev_model (.byte_addr, .chip_sel_n,
        .out_en_n, .write_n, .host_d(byte_lines_out), .host_oe_n(byte_lines_oe_n), .supply_good,
        .byte_lines(byte_lines_in));
    initial begin
        forever #25 aclk = ~aclk;
    end
    task automatic summarize;
        $display("Counts: %0d compares, %0d errors", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bound(input int n);
        if (n >= 100) begin
            num_errors++;
            summarize();
        end
    endtask
    task automatic axw(input logic [3:0] a, input logic [31:0] d);
        int n;
        @(posedge aclk);
        s_awaddr <= a;
        s_wdata <= d;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        s_bready <= 1'b1;
        n = 0;
        // Each channel is released at its own handshake edge
        do begin
            @(posedge aclk);
            n++;
            if (s_awready === 1'b1) s_awvalid <= 1'b0;
            if (s_wready === 1'b1) s_wvalid <= 1'b0;
        end while (s_bvalid !== 1'b1 && n < 100);
        s_bready <= 1'b0;
        chk(32'(s_bresp), 32'h0);
        bound(n);
    endtask
    task automatic axr(input logic [3:0] a, output logic [31:0] d);
        int n;
        @(posedge aclk);
        s_araddr <= a;
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
            if (s_arready === 1'b1) s_arvalid <= 1'b0;
        end while (s_rvalid !== 1'b1 && n < 100);
        d = s_rdata;
        s_rready <= 1'b0;
        chk(32'(s_rresp), 32'h0);
        bound(n);
    endtask
    task automatic dev_op(input logic [16:0] a, input logic [7:0] d, input logic [3:0] cmd);
        int n;
        axw(sram_host_pkg::REG_ADDR, 32'(a));
        axw(sram_host_pkg::REG_WDATA, 32'(d));
        axw(sram_host_pkg::REG_CMD, 32'(cmd));
        n = 0;
        do begin
            axr(sram_host_pkg::REG_STATUS, st);
            n++;
        end while (st[9] !== 1'b0 && n < 100);
        bound(n);
    endtask
    always @(posedge aclk) begin
        if (aresetn && !chip_sel_n && !last_sel_n) chk(32'(byte_addr), 32'(last_addr));
        if (aresetn && !write_n) chk(32'({out_en_n, byte_lines_oe_n}), 32'h2);
        last_addr <= byte_addr;
        last_sel_n <= chip_sel_n;
    end
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (rows[i]) dev_op(rows[i].a, rows[i].d, WR);
        foreach (rows[i]) begin
            dev_op(rows[i].a, 8'h00, RD);
            chk(32'(st[7:0]), 32'(rows[i].d));
        end
        $display("test rows done");
        dev_op(CA, 8'h00, HALT);
        dev_op(CA, 8'h00, RD);
        chk(32'(st[7:0]), 32'h40);
        dev_op(SA, 8'h00, RD);
        s0 = st[7:0];
        repeat (2 * TICK) @(posedge aclk);
        dev_op(SA, 8'h00, RD);
        chk(32'(st[7:0]), 32'(s0));
        dev_op(CA, 8'h00, REL);
        repeat (TICK / 2) @(posedge aclk);
        dev_op(SA, 8'h00, RD);
        chk(32'(st[7:0]), 32'(s0));
        repeat (TICK) @(posedge aclk);
        dev_op(SA, 8'h00, RD);
        chk(32'(st[7:0] !== s0 && st[3:0] <= 4'h9), 32'h1);
        $display("test halt done");
        dev_op(CA, 8'h00, HALT);
        supply_good <= 1'b0;
        dev_op(rows[0].a, 8'h11, WR);
        chk(32'(st[11:10]), 32'h1);
        supply_good <= 1'b1;
        repeat (40) @(posedge aclk);
        dev_op(rows[0].a, 8'h00, RD);
        chk(32'(st[7:0]), 32'(rows[0].d));
        dev_op(CA, 8'h00, RD);
        chk(32'(st[7:6]), 32'h0);
        $display("test supply done");
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        chk(32'({chip_sel_n, out_en_n, write_n, byte_lines_oe_n, byte_addr}), 32'h1e0000);
        aresetn <= 1'b1;
        dev_op(rows[1].a, 8'h00, RD);
        chk(32'(st[7:0]), 32'(rows[1].d));
        $display("test reset done");
        summarize();
    end
endmodule
`default_nettype wire
